/* core/mcs_regs.svh */
// constants for the mode control and standby block
// Summary of operation
// - mode bit 0 picks rotate-left fill: accumulator msb or serial input pin
// - mode bit 1 sets key scan pins direction: 0 input, 1 output
// - mode bit 2 stops (0) or runs (1) the transmit down counter
// - mode bit 3 picks carrier divide: 0 by 8, 1 by 12
// - large ROM: mode bits 4 and 5 give data pointer address bits 8, 9
// - small ROM: bit 4 gives pointer msb; bit 5 always written 0
// - mode bit 6: standby keeps oscillator (0) or stops it (1)
// - reset clears mode bits 0, 8 and 9; others keep any value
// - standby stops execution and keeps all registers and memory unchanged
// - stop mode halts the oscillator so clocked functions cease until wake
// - stop standby during timer count freezes cpu, oscillator stops at zero
// - halt mode keeps clock running while cpu idles until release
// - operand low bits pick wake: serial, key scan, key input, timer
// - operand bit 3 picks wake level: 0 low, 1 high
// - serial wake while rotate fill is accumulator msb releases at once
// - key scan wake only counts while key scan pins are inputs
// - all clear pin low resets cpu including program counter
// - low voltage reset drives transmit indicator low
// - option picks divide-by-12 carrier duty: half or one third
// - hang-up option resets in stop if keys are inputs or any low
// - wake condition marked unused, true in halt, resets the device
// - timer reaching zero ends a timer wait standby
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH
// mode control bit positions
`define MCS_MB_ROT 0
`define MCS_MB_KDIR 1
`define MCS_MB_TRUN 2
`define MCS_MB_CSEL 3
`define MCS_MB_DP8 4
`define MCS_MB_DP9 5
`define MCS_MB_STOP 6
// reset values and internal-reset keep mask
`define MCS_MODE_RST 10'h000
`define MCS_MODE_KEEP 10'h0fe
// timing in system clocks
`define MCS_MC_LAST 3'h7
`define MCS_DIV8_LAST 4'h7
`define MCS_DIV12_LAST 4'hb
`define MCS_HI_DIV8 4'h4
`define MCS_HI_HALF 4'h6
`define MCS_HI_THIRD 4'h4
`endif

/* core/mcs_pkg.sv */
// types shared by the mode control and standby block
`default_nettype none
package mcs_pkg;
    typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_STOP_WAIT, ST_STOP} mcs_state_type;
    typedef enum logic [2:0] {
        WK_SERIAL = 3'h0,
        WK_KEY_IO = 3'h1,
        WK_KEY_IN = 3'h2,
        WK_TIMER = 3'h3
    } mcs_wake_type;
endpackage : mcs_pkg
`default_nettype wire

/* core/mcs_carrier_gen.sv */
// carrier divider with selectable divide and duty
`timescale 1ns/1ps
`default_nettype none
`include "mcs_regs.svh"
module mcs_carrier_gen import mcs_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic en,
    input wire logic div12,
    input wire logic duty_third,
    // carrier
    output logic carrier
);
    logic [3:0] cnt_r;
    logic [3:0] last;
    logic [3:0] hi;

    // period and high time per divide and duty option
    assign last = div12 ? `MCS_DIV12_LAST : `MCS_DIV8_LAST;
    assign hi = div12 ? (duty_third ? `MCS_HI_THIRD : `MCS_HI_HALF) : `MCS_HI_DIV8;

    // phase counter restarts with every enable so bursts begin high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 4'h0;
        end else if (!en || cnt_r >= last) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // output flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            carrier <= 1'b0;
        end else begin
            carrier <= en && (cnt_r < hi);
        end
    end

    // one third duty at divide by 12: four high then low
    chk_duty_third: assert property (@(posedge clk) disable iff (!nrst || !en || !div12 || !duty_third)
        $rose(carrier) |-> carrier [*4] ##1 !carrier) else $error("third duty high time wrong");
endmodule : mcs_carrier_gen
`default_nettype wire

/* core/mcs_wake_detect.sv */
// standby release and unused-condition decode
`timescale 1ns/1ps
`default_nettype none
module mcs_wake_detect import mcs_pkg::*; (
    // selection
    input wire logic [3:0] operand,
    input wire logic rot_serial,
    input wire logic key_io_inputs,
    // sources
    input wire logic serial_in,
    input wire logic [7:0] key_scan_io_in,
    input wire logic [3:0] key_input,
    input wire logic timer_zero,
    // unused-condition options
    input wire logic opt_unused_serial,
    input wire logic opt_unused_key_io,
    input wire logic opt_unused_key_in,
    // results
    output logic hit,
    output logic unused_hit
);
    logic lvl;
    logic m_ser;
    logic m_kio;
    logic m_ki;

    // level compare: any pin at the chosen level counts
    assign lvl = operand[3];
    assign m_ser = (serial_in == lvl);
    assign m_kio = |(key_scan_io_in ~^ {8{lvl}});
    assign m_ki = |(key_input ~^ {4{lvl}});

    // source select; codes 4 to 7 never release
    always_comb begin
        unique case (operand[2:0])
            WK_SERIAL: hit = rot_serial ? m_ser : 1'b1;
            WK_KEY_IO: hit = key_io_inputs && m_kio;
            WK_KEY_IN: hit = m_ki;
            WK_TIMER: hit = timer_zero;
            default: hit = 1'b0;
        endcase
    end

    // a condition marked unused that comes true asks for a reset
    assign unused_hit = (opt_unused_serial && rot_serial && m_ser) ||
                        (opt_unused_key_io && key_io_inputs && m_kio) ||
                        (opt_unused_key_in && m_ki);
endmodule : mcs_wake_detect
`default_nettype wire

/* core/mcs_top.sv */
// mode control register, standby sequencing and reset paths
`timescale 1ns/1ps
`default_nettype none
`include "mcs_regs.svh"
module mcs_top import mcs_pkg::*; #(
    parameter bit LARGE_ROM = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // mode control register port
    input wire logic mode_wr,
    input wire logic [9:0] mode_wdata,
    output logic [9:0] mode_rdata,
    // standby instruction
    input wire logic halt_exec,
    input wire logic [3:0] halt_operand,
    output logic cpu_stall,
    output logic osc_enable,
    output logic wake_pulse,
    // reset sources
    input wire logic all_clear_n,
    input wire logic lvd_reset,
    output logic cpu_reset,
    // pins and datapath
    input wire logic serial_in,
    input wire logic [7:0] key_scan_io_in,
    input wire logic [3:0] key_input,
    input wire logic acc_msb,
    output logic rotate_in_bit,
    output logic key_scan_io_oe,
    // timer and transmit
    input wire logic timer_zero,
    input wire logic carrier_enable,
    output logic timer_run,
    output logic carrier_output,
    output logic tx_indicator,
    output logic [1:0] dp_high,
    // mask options
    input wire logic opt_duty_third,
    input wire logic opt_key_io_hangup,
    input wire logic opt_unused_serial,
    input wire logic opt_unused_key_io,
    input wire logic opt_unused_key_in
);
    // ************************************************
    // state
    // ************************************************
    logic [9:0] mode_r;
    logic [3:0] op_r;
    logic [2:0] mc_cnt_r;
    mcs_state_type state_r;
    mcs_state_type state_nxt;
    logic cpu_reset_r;
    logic mc_tick;
    logic sample;
    logic hit;
    logic unused_hit;
    logic hangup;
    logic self_rst;
    logic wake;
    logic car_en;

    // ************************************************
    // mode control register
    // ************************************************

    // writes only land while running; internal reset clears bits 0, 8, 9
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= `MCS_MODE_RST;
        end else if (cpu_reset_r) begin
            mode_r <= mode_r & `MCS_MODE_KEEP;
        end else if (mode_wr && state_r == ST_RUN) begin
            mode_r <= mode_wdata;
        end
    end

    // register-driven control outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_rdata <= `MCS_MODE_RST;
            key_scan_io_oe <= 1'b0;
            timer_run <= 1'b0;
            dp_high <= 2'h0;
        end else begin
            mode_rdata <= mode_r;
            key_scan_io_oe <= mode_r[`MCS_MB_KDIR];
            timer_run <= mode_r[`MCS_MB_TRUN];
            // small part ties address bit 9 low whatever bit 5 holds
            dp_high <= {LARGE_ROM ? mode_r[`MCS_MB_DP9] : 1'b0, mode_r[`MCS_MB_DP8]};
        end
    end

    // rotate fill bit follows the pin or accumulator msb per bit 0, one clock behind
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rotate_in_bit <= 1'b0;
        end else begin
            rotate_in_bit <= mode_r[`MCS_MB_ROT] ? serial_in : acc_msb;
        end
    end

    // ************************************************
    // machine cycle and wake sampling
    // ************************************************

    // eight clocks a machine cycle, the timer's own pace
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mc_cnt_r <= 3'h0;
        end else if (cpu_reset_r) begin
            mc_cnt_r <= 3'h0;
        end else begin
            mc_cnt_r <= mc_cnt_r + 3'h1;
        end
    end

    assign mc_tick = (mc_cnt_r == `MCS_MC_LAST);
    // with the oscillator stopped there are no machine cycles, so pins are watched every clock
    assign sample = (state_r == ST_STOP) || mc_tick;

    mcs_wake_detect u_wake (
        .operand(op_r),
        .rot_serial(mode_r[`MCS_MB_ROT]),
        .key_io_inputs(!mode_r[`MCS_MB_KDIR]),
        .serial_in(serial_in),
        .key_scan_io_in(key_scan_io_in),
        .key_input(key_input),
        .timer_zero(timer_zero),
        .opt_unused_serial(opt_unused_serial),
        .opt_unused_key_io(opt_unused_key_io),
        .opt_unused_key_in(opt_unused_key_in),
        .hit(hit),
        .unused_hit(unused_hit)
    );

    // hang-up: keys left as inputs or any key pin low while stopped
    assign hangup = opt_key_io_hangup && (!mode_r[`MCS_MB_KDIR] || !(&key_scan_io_in));
    assign self_rst = (state_r == ST_HALT && mc_tick && unused_hit) ||
                      (state_r == ST_STOP && hangup);
    assign wake = (state_r != ST_RUN) && sample && hit && !self_rst;

    // ************************************************
    // standby sequencer
    // ************************************************

    // next state; stop waits for the counter when it is still running
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RUN: begin
                if (halt_exec) begin
                    if (!mode_r[`MCS_MB_STOP]) begin
                        state_nxt = ST_HALT;
                    end else if (mode_r[`MCS_MB_TRUN] && !timer_zero) begin
                        state_nxt = ST_STOP_WAIT;
                    end else begin
                        state_nxt = ST_STOP;
                    end
                end
            end
            ST_HALT: begin
                if (wake) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_STOP_WAIT: begin
                if (wake) begin
                    state_nxt = ST_RUN;
                end else if (timer_zero) begin
                    state_nxt = ST_STOP;
                end
            end
            ST_STOP: begin
                if (wake) begin
                    state_nxt = ST_RUN;
                end
            end
        endcase
    end

    // state, operand capture and the flopped standby outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_RUN;
            op_r <= 4'h0;
            cpu_stall <= 1'b0;
            osc_enable <= 1'b1;
            wake_pulse <= 1'b0;
        end else if (cpu_reset_r) begin
            state_r <= ST_RUN;
            op_r <= 4'h0;
            cpu_stall <= 1'b0;
            osc_enable <= 1'b1;
            wake_pulse <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_RUN && halt_exec) begin
                op_r <= halt_operand;
            end
            cpu_stall <= (state_nxt != ST_RUN);
            osc_enable <= (state_nxt != ST_STOP);
            wake_pulse <= wake;
        end
    end

    // ************************************************
    // resets, carrier and transmit indicator
    // ************************************************

    // all clear pin, low voltage and self resets merge into one flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpu_reset_r <= 1'b1;
        end else begin
            cpu_reset_r <= !all_clear_n || lvd_reset || self_rst;
        end
    end

    assign cpu_reset = cpu_reset_r;

    // no carrier while stopped or held in reset
    assign car_en = carrier_enable && osc_enable && !cpu_reset_r;

    mcs_carrier_gen u_carrier (
        .clk(clk),
        .nrst(nrst),
        .en(car_en),
        .div12(mode_r[`MCS_MB_CSEL]),
        .duty_third(opt_duty_third),
        .carrier(carrier_output)
    );

    // indicator is low while carrier goes out; low voltage forces it low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_indicator <= 1'b1;
        end else if (lvd_reset) begin
            tx_indicator <= 1'b0;
        end else begin
            tx_indicator <= !car_en;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    sequence s_run_write;
        mode_wr && state_r == ST_RUN && !cpu_reset_r;
    endsequence

    sequence s_halt_tick;
        state_r == ST_HALT && mc_tick && !self_rst && !cpu_reset_r;
    endsequence

    chk_kdir_follows: assert property (@(posedge clk) disable iff (!nrst)
        s_run_write |-> ##2 key_scan_io_oe == $past(mode_wdata[1], 2)) else $error("key direction not applied");
    chk_trun_follows: assert property (@(posedge clk) disable iff (!nrst)
        s_run_write |-> ##2 timer_run == $past(mode_wdata[2], 2)) else $error("timer run not applied");
    chk_reset_clears: assert property (@(posedge clk) disable iff (!nrst)
        cpu_reset_r |=> mode_r[0] == 1'b0 && mode_r[9:8] == 2'h0) else $error("reset left mode bits set");
    chk_stop_delay: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == ST_STOP_WAIT && !timer_zero) |-> osc_enable && cpu_stall) else $error("stopped before zero");
    chk_stop_osc: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_STOP |-> !osc_enable && cpu_stall) else $error("oscillator runs in stop");
    chk_halt_clock: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_HALT |-> osc_enable && cpu_stall) else $error("halt lost clock or stall");
    chk_timer_wake: assert property (@(posedge clk) disable iff (!nrst)
        s_halt_tick ##0 (op_r[2:0] == 3'h3 && timer_zero) |=> state_r == ST_RUN && !cpu_stall && wake_pulse)
        else $error("timer zero did not wake");
    chk_serial_forced: assert property (@(posedge clk) disable iff (!nrst)
        s_halt_tick ##0 (op_r[2:0] == 3'h0 && !mode_r[0]) |=> !cpu_stall) else $error("forced release missed");
    chk_no_early_wake: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == ST_HALT && !mc_tick) |=> state_r == ST_HALT || $past(cpu_reset_r)) else $error("woke off tick");
    chk_all_clear: assert property (@(posedge clk) disable iff (!nrst)
        !all_clear_n |=> cpu_reset ##1 (state_r == ST_RUN && !cpu_stall)) else $error("all clear ignored");
    chk_lvd_indicator: assert property (@(posedge clk) disable iff (!nrst)
        lvd_reset |=> !tx_indicator) else $error("indicator high in low voltage");
    chk_hangup_reset: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == ST_STOP && opt_key_io_hangup && !mode_r[1] && !cpu_reset_r) |=> cpu_reset)
        else $error("hang-up not reset");
endmodule : mcs_top
`default_nettype wire

/* test/test_mode_control_and_standby.sv */
// self-checking testbench for the mode control and standby block
`timescale 1ns/1ps
`default_nettype none
module test_mode_control_and_standby import mcs_pkg::*;;
    // ********************************
    // signals and counters
    // ********************************
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic mode_wr = 1'b0, halt_exec = 1'b0, all_clear_n = 1'b1, lvd_reset = 1'b0;
    logic [9:0] mode_wdata = 10'h000;
    logic [3:0] halt_operand = 4'h0, key_input = 4'h0;
    logic [7:0] key_scan_io_in = 8'h00;
    logic serial_in = 1'b0, acc_msb = 1'b0, timer_zero = 1'b0, carrier_enable = 1'b0;
    logic opt_duty_third = 1'b0, opt_key_io_hangup = 1'b0;
    logic opt_unused_serial = 1'b0, opt_unused_key_io = 1'b0, opt_unused_key_in = 1'b0;
    logic [9:0] mode_rdata;
    logic [1:0] dp_high;
    logic cpu_stall, osc_enable, wake_pulse, cpu_reset, rotate_in_bit, key_scan_io_oe;
    logic timer_run, carrier_output, tx_indicator;
    int num_errors = 0;
    int num_checks = 0;
    int h, p;

    // 250 MHz system clock
    always #2 clk = ~clk;

    // ********************************
    // device under test
    // ********************************
    mcs_top #(.LARGE_ROM(1'b1)) u_dut (
        .clk(clk), .nrst(nrst), .mode_wr(mode_wr), .mode_wdata(mode_wdata), .mode_rdata(mode_rdata),
        .halt_exec(halt_exec), .halt_operand(halt_operand), .cpu_stall(cpu_stall),
        .osc_enable(osc_enable), .wake_pulse(wake_pulse), .all_clear_n(all_clear_n),
        .lvd_reset(lvd_reset), .cpu_reset(cpu_reset), .serial_in(serial_in),
        .key_scan_io_in(key_scan_io_in), .key_input(key_input), .acc_msb(acc_msb),
        .rotate_in_bit(rotate_in_bit), .key_scan_io_oe(key_scan_io_oe), .timer_zero(timer_zero),
        .carrier_enable(carrier_enable), .timer_run(timer_run), .carrier_output(carrier_output),
        .tx_indicator(tx_indicator), .dp_high(dp_high), .opt_duty_third(opt_duty_third),
        .opt_key_io_hangup(opt_key_io_hangup), .opt_unused_serial(opt_unused_serial),
        .opt_unused_key_io(opt_unused_key_io), .opt_unused_key_in(opt_unused_key_in)
    );

    // ********************************
    // shared tasks
    // ********************************
    // verdict and end of run, reached from the main sequence or a timeout
    task finish_test;
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task chk(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // the one ns step lets the edge's updates land before anything is sampled
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // one-cycle write pulse, outputs follow two edges later
    task wr(input logic [9:0] d);
        @(posedge clk);
        mode_wr <= 1'b1;
        mode_wdata <= d;
        @(posedge clk);
        mode_wr <= 1'b0;
        tick(1);
    endtask : wr

    task halt(input logic [3:0] op);
        @(posedge clk);
        halt_exec <= 1'b1;
        halt_operand <= op;
        @(posedge clk);
        halt_exec <= 1'b0;
        #1;
    endtask : halt

    // bounded wait: 0 wake pulse, 1 cpu reset, 2 oscillator off, 3 carrier high
    task wait_sig(input int sel, input int lim);
        logic s;
        for (int i = 0; i < lim; i++) begin
            tick(1);
            s = (sel == 0) ? wake_pulse : (sel == 1) ? cpu_reset : (sel == 2) ? !osc_enable : carrier_output;
            if (s === 1'b1) begin
                return;
            end
        end
        num_errors++;
        $display("CHECK FAILED at %0t: wait %h timed out, got %h expected %h", $time, sel, 1'b0, 1'b1);
        finish_test();
    endtask : wait_sig

    // one carrier period measured from a rising edge: high count and full period
    task meas(output int hi, output int per);
        hi = 0;
        per = 0;
        while (carrier_output === 1'b1 && per < 40) begin per++; tick(1); end
        wait_sig(3, 40);
        while (carrier_output === 1'b1 && hi < 40) begin hi++; tick(1); end
        per = hi;
        while (carrier_output !== 1'b1 && per < 40) begin per++; tick(1); end
    endtask : meas

    // ********************************
    // scenarios
    // ********************************
    task t_regs;
        chk(mode_rdata, 10'h000);
        chk({tx_indicator, osc_enable, cpu_stall}, 10'h006);
        wr(10'h03e);
        chk(mode_rdata, 10'h03e);
        chk({key_scan_io_oe, timer_run, dp_high}, 10'h00f);
        wr(10'h010);
        chk({key_scan_io_oe, timer_run, dp_high}, 10'h001);
    endtask : t_regs

    task t_rotate;
        acc_msb <= 1'b0;
        serial_in <= 1'b1;
        wr(10'h001);
        chk(rotate_in_bit, 1'b1);
        wr(10'h000);
        chk(rotate_in_bit, 1'b0);
    endtask : t_rotate

    // low-voltage reset keeps bits 1..7, clears bit 0
    task t_lvd;
        wr(10'h07f);
        lvd_reset <= 1'b1;
        tick(2);
        chk({tx_indicator, cpu_reset}, 10'h001);
        lvd_reset <= 1'b0;
        tick(3);
        chk(mode_rdata, 10'h07e);
        wr(10'h000);
    endtask : t_lvd

    task t_halt_timer;
        halt(4'h3);
        chk({cpu_stall, osc_enable}, 10'h003);
        wr(10'h002);
        tick(3);
        chk(mode_rdata, 10'h000);
        timer_zero <= 1'b1;
        wait_sig(0, 10);
        timer_zero <= 1'b0;
        tick(1);
        chk(cpu_stall, 1'b0);
    endtask : t_halt_timer

    task t_serial;
        wr(10'h001);
        serial_in <= 1'b0;
        halt(4'h8);
        tick(12);
        chk(cpu_stall, 1'b1);
        serial_in <= 1'b1;
        wait_sig(0, 10);
        wr(10'h000);
        serial_in <= 1'b0;
        halt(4'h8);
        wait_sig(0, 10);
    endtask : t_serial

    // key scan wake, then a stall with pins driven, ended by the all clear pin
    task t_key_io;
        halt(4'h9);
        tick(12);
        chk(cpu_stall, 1'b1);
        key_scan_io_in <= 8'h10;
        wait_sig(0, 10);
        wr(10'h002);
        halt(4'h9);
        tick(20);
        chk(cpu_stall, 1'b1);
        all_clear_n <= 1'b0;
        tick(2);
        chk({cpu_reset, cpu_stall}, 10'h002);
        all_clear_n <= 1'b1;
        key_scan_io_in <= 8'h00;
        tick(3);
        wr(10'h000);
    endtask : t_key_io

    task t_stop;
        wr(10'h044);
        halt(4'ha);
        chk({cpu_stall, osc_enable}, 10'h003);
        tick(4);
        chk(osc_enable, 1'b1);
        timer_zero <= 1'b1;
        wait_sig(2, 4);
        key_input <= 4'h1;
        wait_sig(0, 4);
        chk(osc_enable, 1'b1);
        key_input <= 4'h0;
        timer_zero <= 1'b0;
        wr(10'h000);
    endtask : t_stop

    // self resets: unused wake conditions in halt, key hang-up in stop; code 7 never releases
    task t_self_reset;
        opt_unused_key_in <= 1'b1;
        halt(4'h2);
        wait_sig(1, 10);
        opt_unused_key_in <= 1'b0;
        tick(4);
        opt_unused_serial <= 1'b1;
        serial_in <= 1'b1;
        wr(10'h001);
        halt(4'h8);
        wait_sig(1, 10);
        opt_unused_serial <= 1'b0;
        serial_in <= 1'b0;
        tick(4);
        opt_unused_key_io <= 1'b1;
        halt(4'h1);
        wait_sig(1, 10);
        opt_unused_key_io <= 1'b0;
        tick(4);
        halt(4'hf);
        tick(20);
        chk(cpu_stall, 1'b1);
        lvd_reset <= 1'b1;
        tick(2);
        lvd_reset <= 1'b0;
        tick(3);
        opt_key_io_hangup <= 1'b1;
        wr(10'h040);
        halt(4'ha);
        wait_sig(1, 4);
        tick(4);
        key_scan_io_in <= 8'hfe;
        wr(10'h042);
        halt(4'ha);
        wait_sig(1, 4);
        opt_key_io_hangup <= 1'b0;
        key_scan_io_in <= 8'h00;
        tick(4);
        wr(10'h000);
    endtask : t_self_reset

    // second measurement is judged, the first may be a partial period
    task t_carrier;
        carrier_enable <= 1'b1;
        meas(h, p);
        meas(h, p);
        chk(10'(h), 10'h004);
        chk(10'(p), 10'h008);
        chk(tx_indicator, 1'b0);
        wr(10'h008);
        meas(h, p);
        meas(h, p);
        chk(10'(h), 10'h006);
        chk(10'(p), 10'h00c);
        opt_duty_third <= 1'b1;
        meas(h, p);
        meas(h, p);
        chk(10'(h), 10'h004);
        chk(10'(p), 10'h00c);
        carrier_enable <= 1'b0;
        tick(3);
    endtask : t_carrier

    // ********************************
    // main sequence
    // ********************************
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        tick(4);
        t_regs();
        t_rotate();
        t_lvd();
        t_halt_timer();
        t_serial();
        t_key_io();
        t_stop();
        t_self_reset();
        t_carrier();
        finish_test();
    end
endmodule : test_mode_control_and_standby
`default_nettype wire
